// >>> verilog/srt_cfg.svh
// Constants for the split reload timer: register addresses, bit positions,
// reset values and prescaler counts.
// Assumes an 8-bit special function register space with one access per cycle.
`ifndef SRT_CFG_SVH
`define SRT_CFG_SVH
`define SRT_ADDR_CTRL 8'h91
`define SRT_ADDR_RLD_LO 8'h92
`define SRT_ADDR_RLD_HI 8'h93
`define SRT_ADDR_CNT_LO 8'h94
`define SRT_ADDR_CNT_HI 8'h95
`define SRT_BIT_HOVF 7
`define SRT_BIT_LOVF 6
`define SRT_BIT_LIEN 5
`define SRT_BIT_CAPEN 4
`define SRT_BIT_SPLIT 3
`define SRT_BIT_RUN 2
`define SRT_ALT_MSB 1
`define SRT_ALT_LSB 0
`define SRT_CTRL_RESET 8'h00
`define SRT_BYTE_RESET 8'h00
`define SRT_BYTE_MAX 8'hFF
`define SRT_WORD_MAX 16'hFFFF
`define SRT_DIV12_LAST 4'hB
`define SRT_DIV8_LAST 3'h7
`endif

// >>> verilog/srt_pkg.sv
// Types for the split reload timer.
// Assumes srt_cfg.svh supplies the numeric constants.
package srt_pkg;
   // Alternative clock source encoding, in field order 00, 01, 10, 11.
   typedef enum logic [1:0] {
      SRT_ALT_DIV12,
      SRT_ALT_EXT8,
      SRT_ALT_RSVD,
      SRT_ALT_LFO8
   } srt_alt_t;
endpackage : srt_pkg

// >>> verilog/srt_timer.sv
// Split reload timer: control register, counter, reload pair and clock sources.
// Assumes a CPU drives single-cycle register strobes synchronous to clk_sys,
// and that the per-byte clock select bits and the interrupt enable come from
// registers held elsewhere.
//
// Function
// [R1] High byte rollover from 0xFF to 0x00 sets the high overflow flag.
// [R2] In 16-bit mode the high flag sets on the 0xFFFF to 0x0000 wrap.
// [R3] A set high flag requests an interrupt while timer interrupts are enabled.
// [R4] Low byte rollover sets the low overflow flag in both modes.
// [R5] Only a software write of zero clears either overflow flag.
// [R6] Low flag requests an interrupt when low-byte enable and interrupts are on.
// [R7] With capture enabled, each oscillator falling edge copies count into reload.
// [R8] In capture mode each oscillator falling edge requests an interrupt.
// [R9] Split bit selects one 16-bit or two 8-bit auto-reload timers.
// [R10] Run bit set lets the timer count; clear holds the count.
// [R11] In split mode run gates only the high byte; low byte always counts.
// [R12] Alt select: 00 system_clock/12, 01 external/8, 10 reserved, 11 oscillator/8.
// [R13] External and oscillator sources are synchronised except in suspend.
// [R14] In split mode one alt select value serves both byte counters.
// [R15] Each byte's own select bit picks system clock or the alt source.
// [R16] In 16-bit mode the wrap loads the reload pair with the flag set.
// [R17] In split mode each byte reloads from its own reload byte on overflow.
// [R18] Interrupt requests are raised only while the timer interrupt enable is set.
// [R19] Counters advance once per selected tick; reserved source gives no ticks.
`timescale 1ns/10ps
`include "srt_cfg.svh"

module srt_timer
   import srt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic high_byte_clock_select,
   input wire logic low_byte_clock_select,
   input wire logic timer_irq_enable,
   input wire logic suspend,
   input wire logic ext_osc_in,
   input wire logic low_freq_osc_in,
   output logic timer_irq
);

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
      addr_hit = (a == off);
   endfunction : addr_hit

   // A byte advances on every system clock when its select bit is set,
   // otherwise on the shared alternative source.
   function automatic logic byte_tick(input logic sys_sel, input srt_alt_t alt,
                                      input logic t12, input logic tx,
                                      input logic tl);
      logic t;
      t = 1'b0;
      if (sys_sel) begin
         t = 1'b1; // see [R15]
      end else begin
         unique case (alt) // see [R12] see [R14]
            SRT_ALT_DIV12: t = t12;
            SRT_ALT_EXT8: t = tx;
            SRT_ALT_RSVD: t = 1'b0; // see [R19]
            SRT_ALT_LFO8: t = tl;
         endcase
      end
      byte_tick = t;
   endfunction : byte_tick

   // System clock divided by 12.
   logic [3:0] pre_reg;
   logic [3:0] pre_next;
   logic tick12;

   always_comb begin
      tick12 = (pre_reg == `SRT_DIV12_LAST);
      pre_next = tick12 ? 4'h0 : pre_reg + 4'h1;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pre_reg <= 4'h0;
      end else begin
         pre_reg <= pre_next;
      end
   end

   // Channel 0 is the external oscillator, channel 1 the low-frequency one.
   // Outside suspend each input passes two flip-flops; in suspend the raw
   // level drives the edge detector directly.
   logic [1:0] src_raw;
   logic [1:0] src_tick;
   logic [1:0] src_fall;

   assign src_raw = {low_freq_osc_in, ext_osc_in};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_src
         logic s1_reg;
         logic s2_reg;
         logic lvl_reg;
         logic [2:0] div_reg;
         logic s1_next;
         logic s2_next;
         logic lvl_next;
         logic [2:0] div_next;
         logic rise;

         always_comb begin
            s1_next = src_raw[g];
            s2_next = s1_reg;
            lvl_next = suspend ? src_raw[g] : s2_reg; // see [R13]
            rise = lvl_next & ~lvl_reg;
            src_fall[g] = ~lvl_next & lvl_reg;
            div_next = rise ? div_reg + 3'h1 : div_reg;
            src_tick[g] = rise && (div_reg == `SRT_DIV8_LAST);
         end

         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               lvl_reg <= 1'b0;
               div_reg <= 3'h0;
            end else begin
               s1_reg <= s1_next;
               s2_reg <= s2_next;
               lvl_reg <= lvl_next;
               div_reg <= div_next;
            end
         end
      end
   endgenerate

   // Control, count and reload registers.
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] cnt_lo_reg;
   logic [7:0] cnt_lo_next;
   logic [7:0] cnt_hi_reg;
   logic [7:0] cnt_hi_next;
   logic [7:0] rld_lo_reg;
   logic [7:0] rld_lo_next;
   logic [7:0] rld_hi_reg;
   logic [7:0] rld_hi_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic irq_reg;
   logic irq_next;

   srt_alt_t alt;
   logic run;
   logic split;
   logic tick_lo;
   logic tick_hi;
   logic set_hovf;
   logic set_lovf;
   logic capture;

   always_comb begin
      alt = srt_alt_t'(ctrl_reg[`SRT_ALT_MSB:`SRT_ALT_LSB]);
      run = ctrl_reg[`SRT_BIT_RUN];
      split = ctrl_reg[`SRT_BIT_SPLIT];
      tick_lo = byte_tick(low_byte_clock_select, alt, tick12, src_tick[0], src_tick[1]);
      tick_hi = byte_tick(high_byte_clock_select, alt, tick12, src_tick[0], src_tick[1]);
      capture = ctrl_reg[`SRT_BIT_CAPEN] & src_fall[1];
      set_hovf = 1'b0;
      set_lovf = 1'b0;
      cnt_lo_next = cnt_lo_reg;
      cnt_hi_next = cnt_hi_reg;
      rld_lo_next = rld_lo_reg;
      rld_hi_next = rld_hi_reg;

      if (!split) begin
         // One 16-bit timer clocked through the low byte's source.
         if (run && tick_lo) begin // see [R10] see [R9]
            if ({cnt_hi_reg, cnt_lo_reg} == `SRT_WORD_MAX) begin
               cnt_hi_next = rld_hi_reg; // see [R16]
               cnt_lo_next = rld_lo_reg;
               set_hovf = 1'b1; // see [R2] see [R1]
               set_lovf = 1'b1; // see [R4]
            end else begin
               {cnt_hi_next, cnt_lo_next} = {cnt_hi_reg, cnt_lo_reg} + 16'h1;
               set_lovf = (cnt_lo_reg == `SRT_BYTE_MAX);
            end
         end
      end else begin
         if (tick_lo) begin // see [R11]
            if (cnt_lo_reg == `SRT_BYTE_MAX) begin
               cnt_lo_next = rld_lo_reg; // see [R17]
               set_lovf = 1'b1; // see [R4]
            end else begin
               cnt_lo_next = cnt_lo_reg + 8'h1; // see [R19]
            end
         end
         if (run && tick_hi) begin // see [R11]
            if (cnt_hi_reg == `SRT_BYTE_MAX) begin
               cnt_hi_next = rld_hi_reg; // see [R17]
               set_hovf = 1'b1; // see [R1]
            end else begin
               cnt_hi_next = cnt_hi_reg + 8'h1;
            end
         end
      end

      // A software write to a count byte takes precedence over counting.
      if (sfr_wr && addr_hit(sfr_addr, `SRT_ADDR_CNT_LO)) begin
         cnt_lo_next = sfr_wdata;
      end
      if (sfr_wr && addr_hit(sfr_addr, `SRT_ADDR_CNT_HI)) begin
         cnt_hi_next = sfr_wdata;
      end
      if (sfr_wr && addr_hit(sfr_addr, `SRT_ADDR_RLD_LO)) begin
         rld_lo_next = sfr_wdata;
      end
      if (sfr_wr && addr_hit(sfr_addr, `SRT_ADDR_RLD_HI)) begin
         rld_hi_next = sfr_wdata;
      end

      // Capture copies the current count and wins over a reload write.
      if (capture) begin
         rld_hi_next = cnt_hi_reg; // see [R7]
         rld_lo_next = cnt_lo_reg;
         set_hovf = 1'b1; // see [R8]
      end

      ctrl_next = ctrl_reg;
      if (sfr_wr && addr_hit(sfr_addr, `SRT_ADDR_CTRL)) begin
         ctrl_next = sfr_wdata; // see [R5]
      end
      // A hardware set in the cycle of a clearing write is not lost.
      ctrl_next[`SRT_BIT_HOVF] = ctrl_next[`SRT_BIT_HOVF] | set_hovf; // see [R5]
      ctrl_next[`SRT_BIT_LOVF] = ctrl_next[`SRT_BIT_LOVF] | set_lovf; // see [R5]

      irq_next = timer_irq_enable // see [R18]
         & (ctrl_reg[`SRT_BIT_HOVF] // see [R3] see [R8]
            | (ctrl_reg[`SRT_BIT_LIEN] & ctrl_reg[`SRT_BIT_LOVF])); // see [R6]

      rdata_next = rdata_reg;
      if (sfr_rd) begin
         if (addr_hit(sfr_addr, `SRT_ADDR_CTRL)) begin
            rdata_next = ctrl_reg;
         end else if (addr_hit(sfr_addr, `SRT_ADDR_RLD_LO)) begin
            rdata_next = rld_lo_reg;
         end else if (addr_hit(sfr_addr, `SRT_ADDR_RLD_HI)) begin
            rdata_next = rld_hi_reg;
         end else if (addr_hit(sfr_addr, `SRT_ADDR_CNT_LO)) begin
            rdata_next = cnt_lo_reg;
         end else if (addr_hit(sfr_addr, `SRT_ADDR_CNT_HI)) begin
            rdata_next = cnt_hi_reg;
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `SRT_CTRL_RESET;
         cnt_lo_reg <= `SRT_BYTE_RESET;
         cnt_hi_reg <= `SRT_BYTE_RESET;
         rld_lo_reg <= `SRT_BYTE_RESET;
         rld_hi_reg <= `SRT_BYTE_RESET;
         rdata_reg <= 8'h00;
         irq_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         cnt_lo_reg <= cnt_lo_next;
         cnt_hi_reg <= cnt_hi_next;
         rld_lo_reg <= rld_lo_next;
         rld_hi_reg <= rld_hi_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign sfr_rdata = rdata_reg;
   assign timer_irq = irq_reg;

endmodule : srt_timer

// >>> sim/srt_timer_assertions.sv
// Port checker for the split reload timer.
// Assumes it is bound onto srt_timer and shares its clock and reset.
`timescale 1ns/10ps
module srt_timer_chk
   import srt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic low_byte_clock_select,
   input wire logic timer_irq_enable,
   input wire logic timer_irq
);
   logic [5:0] sh_reg;
   logic [5:0] sh_next;
   logic rd_ctl;
   logic rd_lo;
   // Software-only control bits are shadowed from the writes.
   assign rd_ctl = sfr_rd && sfr_addr == 8'h91;
   assign rd_lo = sfr_rd && sfr_addr == 8'h94;
   always_comb sh_next = (sfr_wr && sfr_addr == 8'h91) ? sfr_wdata[5:0] : sh_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) sh_reg <= 6'h00;
      else sh_reg <= sh_next;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_irq_gated: assert property (!timer_irq_enable |=> !timer_irq)
      else $error("irq without enable");
   a_irq_source: assert property (rd_ctl |=> timer_irq == ($past(timer_irq_enable)
      && (sfr_rdata[7] || (sfr_rdata[5] && sfr_rdata[6])))) else $error("irq source");
   a_flags_sticky: assert property ((rd_ctl && !sfr_wr) ##1 !sfr_wr ##1 rd_ctl
      |=> (sfr_rdata[7:6] & $past(sfr_rdata[7:6], 2)) == $past(sfr_rdata[7:6], 2))
      else $error("flag dropped");
   a_clear_by_write: assert property ((sfr_wr && sfr_addr == 8'h91 && sfr_wdata == 8'h00
      && sh_reg[4:2] == 3'h0) ##1 !sfr_wr ##1 rd_ctl |=> sfr_rdata[7:6] == 2'b00)
      else $error("flag not cleared");
   a_ctrl_bits_rw: assert property (rd_ctl |=> sfr_rdata[5:0] == $past(sh_reg))
      else $error("control bits");
   a_count_hold: assert property ((rd_lo && !sfr_wr && sh_reg[3:2] == 2'b00) ##1
      !sfr_wr ##1 rd_lo |=> sfr_rdata == $past(sfr_rdata, 2)) else $error("count moved");
   a_split_low_runs: assert property ((rd_lo && !sfr_wr && sh_reg[3] && low_byte_clock_select)
      ##1 (!sfr_wr && low_byte_clock_select) ##1 rd_lo |=> $past(sfr_rdata, 2) >= 8'hFE
      || sfr_rdata == $past(sfr_rdata, 2) + 8'h02) else $error("low byte stalled");
   a_unmapped_zero: assert property (sfr_rd && (sfr_addr < 8'h91 || sfr_addr > 8'h95)
      |=> sfr_rdata == 8'h00) else $error("unmapped read");
   c_irq: cover property (timer_irq);
   c_split_read: cover property (rd_lo && sh_reg[3]);
   c_flag_seen: cover property (rd_ctl ##1 sfr_rdata[7]);
endmodule : srt_timer_chk

bind srt_timer srt_timer_chk u_chk (.*);

// >>> sim/srt_timer_tb.sv
// Self-checking bench for the split reload timer.
// Assumes the port checker is bound in from its own file.
`timescale 1ns/10ps
module srt_timer_tb;
   logic clk_sys = 1'b0, arst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, timer_irq;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v, c;
   logic high_byte_clock_select = 1'b1, low_byte_clock_select = 1'b1, suspend = 1'b0;
   logic timer_irq_enable = 1'b0, ext_osc_in = 1'b0, low_freq_osc_in = 1'b1;
   int n_fail = 0, checks_done = 0, cyc = 0;
   srt_timer u_dut (.*);
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         wrap_up;
      end
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      q = sfr_rdata;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd(a, v);
      chk(v, e);
   endtask : rc
   task automatic ic(input logic e);
      // A captured oscillator edge needs two sync stages, the flag edge and the irq edge.
      repeat (4) @(negedge clk_sys);
      chk({7'h00, timer_irq}, {7'h00, e});
   endtask : ic
   task automatic t_reset;
      for (int a = 8'h90; a <= 8'h95; a++) begin
         rc(8'(a), 8'h00);
      end
      ic(1'b0);
   endtask : t_reset
   task automatic t_wrap;
      wr(8'h95, 8'hFF);
      wr(8'h94, 8'hFF);
      wr(8'h92, 8'h34);
      wr(8'h93, 8'h12);
      wr(8'h91, 8'h04);
      // Stop while writing ones so the fresh flags survive.
      wr(8'h91, 8'hC0);
      rc(8'h91, 8'hC0);
      rc(8'h91, 8'hC0);
      rc(8'h94, 8'h35);
      rc(8'h94, 8'h35);
      rc(8'h95, 8'h12);
      timer_irq_enable = 1'b1;
      ic(1'b1);
      wr(8'h91, 8'h40);
      ic(1'b0);
      wr(8'h91, 8'h60);
      ic(1'b1);
      timer_irq_enable = 1'b0;
      ic(1'b0);
      wr(8'h91, 8'h00);
      rc(8'h91, 8'h00);
   endtask : t_wrap
   task automatic t_split;
      wr(8'h95, 8'h10);
      wr(8'h94, 8'hFE);
      wr(8'h92, 8'h80);
      wr(8'h91, 8'h08);
      rc(8'h95, 8'h10);
      rc(8'h94, 8'h81);
      rc(8'h94, 8'h83);
      rc(8'h91, 8'h48);
   endtask : t_split
   task automatic t_alt;
      int e;
      int t;
      low_byte_clock_select = 1'b0;
      for (int k = 0; k < 4; k++) begin
         wr(8'h91, 8'h00);
         wr(8'h94, 8'h00);
         // The oscillator pass runs with the synchronisers bypassed.
         suspend = (k == 3);
         wr(8'h91, 8'h04 | 8'(k));
         repeat (48) begin
            @(negedge clk_sys);
            ext_osc_in = 1'b1;
            low_freq_osc_in = 1'b1;
            @(negedge clk_sys);
            ext_osc_in = 1'b0;
            low_freq_osc_in = 1'b0;
         end
         wr(8'h91, 8'h00);
         suspend = 1'b0;
         rd(8'h94, v);
         e = (k == 0) ? 8 : (k == 2) ? 0 : 6;
         t = (k == 2) ? 0 : 1;
         chk({7'h00, v >= e - t && v <= e + t}, 8'h01);
      end
   endtask : t_alt
   task automatic t_cap;
      low_byte_clock_select = 1'b1;
      low_freq_osc_in = 1'b1;
      wr(8'h94, 8'h00);
      wr(8'h95, 8'h00);
      wr(8'h91, 8'h14);
      timer_irq_enable = 1'b1;
      repeat (20) @(negedge clk_sys);
      low_freq_osc_in = 1'b0;
      ic(1'b1);
      wr(8'h91, 8'h80);
      rc(8'h91, 8'h80);
      rc(8'h93, 8'h00);
      rd(8'h92, c);
      rd(8'h94, v);
      chk({7'h00, c > 8'h10 && c < v}, 8'h01);
   endtask : t_cap
   initial begin
      repeat (16) @(negedge clk_sys);
      arst_n = 1'b1;
      t_reset;
      t_wrap;
      t_split;
      t_alt;
      t_cap;
      wrap_up;
   end
endmodule : srt_timer_tb
